// ===== logic/ppm_pkg.sv
// Constants and types for the power management capability head block.
// Assumes the function's configuration space is addressed as 64 dwords
// with per-byte enables, as on a conventional configuration cycle.
`default_nettype none

package ppm_pkg;

    // Location of the capabilities pointer in the configuration header
    localparam logic [7:0] PPM_CAP_PTR_LOC = 8'h34;
    // Default capability base that the pointer at 34h hands out
    localparam logic [7:0] PPM_CAP_BASE_DEFAULT = 8'h50;
    // Lowest base outside the predefined configuration header
    localparam logic [7:0] PPM_CAP_BASE_MIN = 8'h40;
    // Byte offsets of the two registers from the capability base
    localparam logic [7:0] PPM_LINK_PTR_OFS = 8'h01;
    localparam logic [7:0] PPM_CAPS_OFS = 8'h02;

    // Link pointer value: no further capability follows
    localparam logic [7:0] PPM_LINK_PTR_RESET = 8'h00;
    // Capability identifier byte is served by a neighbouring block
    localparam logic [7:0] PPM_OTHER_BYTE = 8'h00;

    // Bit index of each power state inside the wake state support field
    localparam int PPM_WAKE_D0 = 0;
    localparam int PPM_WAKE_D1 = 1;
    localparam int PPM_WAKE_D2 = 2;
    localparam int PPM_WAKE_D3HOT = 3;
    localparam int PPM_WAKE_D3COLD = 4;

    // Revision code for the 1.1 power management interface
    localparam logic [2:0] PPM_SPEC_REV = 3'h2;
    // Standby current codes
    localparam logic [2:0] PPM_AUX_SELF_POWERED = 3'h0;
    localparam logic [2:0] PPM_AUX_100MA = 3'h2;
    localparam logic [2:0] PPM_AUX_375MA = 3'h7;
    // Fixed single-bit answers of this device
    localparam logic PPM_DEV_INIT_NEEDED = 1'b0;
    localparam logic PPM_WAKE_CLOCK_NEEDED = 1'b0;
    localparam logic PPM_RESERVED_VALUE = 1'b0;
    // Value of the strap-driven bit until the strap has been caught
    localparam logic PPM_STRAP_RESET = 1'b0;

    // Byte lane width inside a configuration dword
    localparam int PPM_LANE_BITS = 8;
    localparam logic [15:0] PPM_CAPS_RESET = 16'h0000;

    // Power management capabilities word, bit 15 first
    typedef struct packed {
        logic [4:0] wake_state_support;   // 15:11
        logic state_two_support;          // 10
        logic light_sleep_support;        // 9
        logic [2:0] aux_current;          // 8:6
        logic dev_init_needed;            // 5
        logic reserved_zero;              // 4
        logic wake_needs_bus_clock;       // 3
        logic [2:0] pm_spec_revision;     // 2:0
    } ppm_caps_t;

    // One configuration access as presented to the block
    typedef struct packed {
        logic rd;                 // Read strobe, one cycle
        logic wr;                 // Write strobe, one cycle
        logic [5:0] dword;        // Dword index into configuration space
        logic [3:0] byte_en;      // Active-high byte enables
        logic [31:0] wdata;       // Write data, ignored by this block
    } ppm_cfg_req_t;

    // Answer to one configuration access
    typedef struct packed {
        logic ack;                // Access complete, one cycle
        logic hit;                // Access addressed this block's dword
        logic [31:0] rdata;       // Read data, valid with ack
    } ppm_cfg_rsp_t;

endpackage : ppm_pkg

`default_nettype wire

// ===== logic/ppm_strap_sync.sv
// Three-stage synchroniser for a level arriving from a pin.
// Assumes one clock; only the second and third stages are given out.
`default_nettype none
`timescale 1ns/1ps

module ppm_strap_sync
    import ppm_pkg::*;
(
    input wire logic ref_clk_in,      // Block clock
    input wire logic reset_n_in,      // Asynchronous reset, active low
    input wire logic pin_in,          // Raw level from the pin
    output logic stage2_out,          // Second synchroniser stage
    output logic stage3_out           // Third synchroniser stage
);

    logic stage1_reg;
    logic stage2_reg;
    logic stage3_reg;
    logic stage1_next;
    logic stage2_next;
    logic stage3_next;

    // Shift the pin level along the chain
    always_comb
    begin
        stage1_next = pin_in;
        stage2_next = stage1_reg;
        stage3_next = stage2_reg;
    end

    // Chain registers, cleared to the strap's quiet level
    always_ff @(posedge ref_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            stage1_reg <= PPM_STRAP_RESET;
            stage2_reg <= PPM_STRAP_RESET;
            stage3_reg <= PPM_STRAP_RESET;
        end
        else
        begin
            stage1_reg <= stage1_next;
            stage2_reg <= stage2_next;
            stage3_reg <= stage3_next;
        end
    end

    assign stage2_out = stage2_reg;
    assign stage3_out = stage3_reg;

endmodule : ppm_strap_sync

`default_nettype wire

// ===== logic/ppm_cap_regs.sv
// Read-only head of the power management capability: link pointer byte
// and capabilities word of one host-controller function.
// Assumes a configuration decoder that presents one dword access per
// strobe and merges this block's answer when hit is high.
`default_nettype none
`timescale 1ns/1ps

module ppm_cap_regs
    import ppm_pkg::*;
#(
    parameter logic [7:0] CAP_BASE = PPM_CAP_BASE_DEFAULT,
    parameter bit IS_HIGH_SPEED = 1'b0,
    parameter bit DATA_REG_PRESENT = 1'b0,
    parameter logic [2:0] AUX_CURRENT_CODE = PPM_AUX_100MA
)
(
    input wire logic ref_clk_in,            // 20 MHz block clock
    input wire logic reset_n_in,            // Asynchronous reset, low
    input wire logic amber_led_four_strap_in, // Strap pin, async level
    input wire ppm_cfg_req_t cfg_req_in,    // Configuration access
    output ppm_cfg_rsp_t cfg_rsp_out,       // Registered answer
    output logic [15:0] pm_capabilities_out, // Live capabilities word
    output logic strap_locked_out           // Strap value has been caught
);

    // Elaboration checks on the function's options
    initial
    begin
        if (CAP_BASE[1:0] != 2'b00)
        begin
            $error("Capability base must be dword aligned");
        end
        if (CAP_BASE < PPM_CAP_BASE_MIN)
        begin
            $error("Capability base overlaps the fixed header");
        end
    end

    // Capture of the strap level after reset release; two fill states let
    // the pin level reach the second stage before the late stages are compared, so the
    // quiet reset value of the chain is never taken for the strap
    typedef enum logic [1:0] {
        PPM_ST_FILL_A,
        PPM_ST_FILL_B,
        PPM_ST_SETTLE,
        PPM_ST_LOCKED
    } ppm_strap_state_t;

    ppm_strap_state_t strap_state_reg;
    ppm_strap_state_t strap_state_next;
    logic d3cold_wake_reg;
    logic d3cold_wake_next;
    logic locked_reg;
    logic locked_next;
    logic strap_s2;
    logic strap_s3;

    ppm_caps_t caps_reg;
    ppm_caps_t caps_next;
    ppm_cfg_rsp_t rsp_reg;
    ppm_cfg_rsp_t rsp_next;

    logic [5:0] base_dword;
    logic dword_hit;
    logic access;
    logic [7:0] link_lane;
    logic [7:0] caps_lo_lane;
    logic [7:0] caps_hi_lane;
    logic [4:0] wake_bits;

    // Bring the strap pin into the clock domain
    ppm_strap_sync u_strap_sync (
        .ref_clk_in (ref_clk_in),
        .reset_n_in (reset_n_in),
        .pin_in (amber_led_four_strap_in),
        .stage2_out (strap_s2),
        .stage3_out (strap_s3)
    );

    // Latch the strap once the two late stages agree, then hold it
    always_comb
    begin
        strap_state_next = strap_state_reg;
        d3cold_wake_next = d3cold_wake_reg;
        locked_next = locked_reg;
        case (strap_state_reg)
            PPM_ST_FILL_A:
            begin
                strap_state_next = PPM_ST_FILL_B;
            end
            PPM_ST_FILL_B:
            begin
                strap_state_next = PPM_ST_SETTLE;
            end
            PPM_ST_SETTLE:
            begin
                if (strap_s2 == strap_s3)
                begin
                    d3cold_wake_next = strap_s3;
                    locked_next = 1'b1;
                    strap_state_next = PPM_ST_LOCKED;
                end
            end
            PPM_ST_LOCKED:
            begin
                strap_state_next = PPM_ST_LOCKED;
            end
            default:
            begin
                strap_state_next = PPM_ST_FILL_A;
            end
        endcase
    end

    // Strap capture registers
    always_ff @(posedge ref_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            strap_state_reg <= PPM_ST_FILL_A;
            d3cold_wake_reg <= PPM_STRAP_RESET;
            locked_reg <= 1'b0;
        end
        else
        begin
            strap_state_reg <= strap_state_next;
            d3cold_wake_reg <= d3cold_wake_next;
            locked_reg <= locked_next;
        end
    end

    // Assemble the wake state support field
    always_comb
    begin
        wake_bits = 5'h00;
        wake_bits[PPM_WAKE_D0] = IS_HIGH_SPEED;
        wake_bits[PPM_WAKE_D1] = 1'b1;
        wake_bits[PPM_WAKE_D2] = IS_HIGH_SPEED;
        wake_bits[PPM_WAKE_D3HOT] = 1'b1;
        wake_bits[PPM_WAKE_D3COLD] = d3cold_wake_reg;
    end

    // Build the capabilities word from options and strap
    always_comb
    begin
        caps_next = caps_reg;
        caps_next.wake_state_support = wake_bits;
        // D2 only where the function supports it
        caps_next.state_two_support = IS_HIGH_SPEED;
        caps_next.light_sleep_support = 1'b1;
        // Standby current only meaningful with D3cold wake, no data reg
        if (DATA_REG_PRESENT || !wake_bits[PPM_WAKE_D3COLD])
        begin
            caps_next.aux_current = PPM_AUX_SELF_POWERED;
        end
        else
        begin
            caps_next.aux_current = AUX_CURRENT_CODE;
        end
        caps_next.dev_init_needed = PPM_DEV_INIT_NEEDED;
        caps_next.reserved_zero = PPM_RESERVED_VALUE;
        // Clock dependency cannot be claimed without any wake state
        caps_next.wake_needs_bus_clock =
            PPM_WAKE_CLOCK_NEEDED & (|wake_bits);
        caps_next.pm_spec_revision = PPM_SPEC_REV;
    end

    // Capabilities register; only the strap and options ever move it
    always_ff @(posedge ref_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            caps_reg <= PPM_CAPS_RESET;
        end
        else
        begin
            caps_reg <= caps_next;
        end
    end

    // Dword that holds identifier, link pointer and capabilities word
    assign base_dword = CAP_BASE[7:2];
    assign access = cfg_req_in.rd | cfg_req_in.wr;
    assign dword_hit = (cfg_req_in.dword == base_dword);

    // Byte lanes, each gated by its enable
    always_comb
    begin
        link_lane = 8'h00;
        caps_lo_lane = 8'h00;
        caps_hi_lane = 8'h00;
        if (cfg_req_in.byte_en[PPM_LINK_PTR_OFS[1:0]])
        begin
            link_lane = PPM_LINK_PTR_RESET;
        end
        if (cfg_req_in.byte_en[PPM_CAPS_OFS[1:0]])
        begin
            caps_lo_lane = caps_reg[PPM_LANE_BITS-1:0];
        end
        if (cfg_req_in.byte_en[PPM_CAPS_OFS[1:0] + 2'd1])
        begin
            caps_hi_lane = caps_reg[15:PPM_LANE_BITS];
        end
    end

    // Answer every strobe next cycle; reads return lanes, writes drop
    always_comb
    begin
        rsp_next = '0;
        if (access && dword_hit)
        begin
            rsp_next.ack = 1'b1;
            rsp_next.hit = 1'b1;
            if (cfg_req_in.rd)
            begin
                rsp_next.rdata = {caps_hi_lane, caps_lo_lane,
                                  link_lane, PPM_OTHER_BYTE};
            end
            else
            begin
                rsp_next.rdata = '0;
            end
        end
        else if (access)
        begin
            // Other dwords complete with no data and no hit
            rsp_next.ack = 1'b1;
        end
    end

    // Answer register feeding the bus outputs
    always_ff @(posedge ref_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            rsp_reg <= '0;
        end
        else
        begin
            rsp_reg <= rsp_next;
        end
    end

    // Outputs straight from flip-flops
    assign cfg_rsp_out = rsp_reg;
    assign pm_capabilities_out = caps_reg;
    assign strap_locked_out = locked_reg;

endmodule : ppm_cap_regs

`default_nettype wire

// ===== tb/ppm_cap_regs_props.sv
// Checker for the capability head block, watching the top's ports only.
// Assumes one clock domain and a strap held steady around reset release.
`default_nettype none
`timescale 1ns/1ps

module ppm_cap_regs_props
    import ppm_pkg::*;
#(
    parameter logic [7:0] CAP_BASE = PPM_CAP_BASE_DEFAULT,
    parameter bit IS_HIGH_SPEED = 1'b0,
    parameter bit DATA_REG_PRESENT = 1'b0,
    parameter logic [2:0] AUX_CURRENT_CODE = PPM_AUX_100MA
)
(
    input wire logic ref_clk_in, // Block clock
    input wire logic reset_n_in, // Asynchronous reset, low
    input wire logic amber_led_four_strap_in, // Strap pin
    input wire ppm_cfg_req_t cfg_req_in, // Configuration access
    input wire ppm_cfg_rsp_t cfg_rsp_out, // Registered answer
    input wire logic [15:0] pm_capabilities_out, // Capabilities word
    input wire logic strap_locked_out // Strap caught
);
    default clocking dcb @(posedge ref_clk_in);
    endclocking
    default disable iff (!reset_n_in);

    // Request decode shared by the properties
    logic req_any;
    logic req_here;
    logic [15:0] caps;
    assign req_any = cfg_req_in.rd | cfg_req_in.wr;
    assign req_here = req_any && (cfg_req_in.dword == CAP_BASE[7:2]);
    assign caps = pm_capabilities_out;

    // Answer timing and decode
    ack_follows_req_a: assert property (
        cfg_rsp_out.ack == $past(req_any))
        else $error("ack does not follow the request by one cycle");
    hit_decode_a: assert property (
        cfg_rsp_out.hit == $past(req_here))
        else $error("hit does not match the capability dword");
    idle_quiet_a: assert property (
        !cfg_rsp_out.ack |-> cfg_rsp_out.rdata == 32'h0 && !cfg_rsp_out.hit)
        else $error("answer lines busy without ack");
    write_no_data_a: assert property (
        cfg_req_in.wr && !cfg_req_in.rd |=> cfg_rsp_out.rdata == 32'h0)
        else $error("write returned data");
    link_ptr_zero_a: assert property (
        req_here && cfg_req_in.rd |=> cfg_rsp_out.rdata[15:0] == 16'h0)
        else $error("link pointer lane not zero");
    caps_read_a: assert property (
        req_here && cfg_req_in.rd && (&cfg_req_in.byte_en[3:2])
        ##1 $stable(caps) |-> cfg_rsp_out.rdata[31:16] == caps)
        else $error("read word differs from capabilities");

    // Field contents once the strap is caught, and the time taken to catch it
    fixed_bits_a: assert property (
        $past(strap_locked_out) |-> caps[14] && caps[12] && caps[9]
        && caps[5:0] == 6'h02)
        else $error("fixed capability bits wrong");
    speed_bits_a: assert property (
        $past(strap_locked_out) |-> caps[13] == IS_HIGH_SPEED
        && caps[11] == IS_HIGH_SPEED && caps[10] == IS_HIGH_SPEED)
        else $error("function dependent bits wrong");
    aux_field_a: assert property (
        $past(strap_locked_out) |-> caps[8:6] == ((caps[15]
        && !DATA_REG_PRESENT) ? AUX_CURRENT_CODE : 3'h0))
        else $error("standby current field wrong");
    strap_hold_a: assert property (
        $past(strap_locked_out) && strap_locked_out
        |=> strap_locked_out && $stable(caps[15]))
        else $error("strap bit moved after lock");
    lock_time_a: assert property (
        $rose(reset_n_in) |-> ##[2:6] strap_locked_out)
        else $error("strap not caught in time");

    // Main scenarios reached
    cover property (req_here && cfg_req_in.rd);
    cover property (req_here && cfg_req_in.wr);
    cover property (req_any && !req_here);
    cover property (strap_locked_out && amber_led_four_strap_in);
endmodule : ppm_cap_regs_props

`default_nettype wire

// ===== tb/ppm_cap_regs_tb_top.sv
// Testbench: full-speed and high-speed copies fed the same accesses.
// Assumes the checker is bound to every copy of the block.
`default_nettype none
`timescale 1ns/1ps

module ppm_cap_regs_tb_top
    import ppm_pkg::*;
();
    localparam logic [5:0] BASE_DW = PPM_CAP_BASE_DEFAULT[7:2];
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic strap = 1'b0;
    logic held = 1'b0;
    ppm_cfg_req_t req = '0;
    ppm_cfg_rsp_t rsp_fs;
    ppm_cfg_rsp_t rsp_hs;
    logic [15:0] caps_fs;
    logic [15:0] caps_hs;
    logic lock_fs;
    logic lock_hs;
    ppm_cfg_rsp_t rsp_dr;
    logic [15:0] caps_dr;
    logic lock_dr;
    int miscompares = 0;
    int checks_done = 0;

    // 20 MHz clock
    always #25 clk = ~clk;

    ppm_cap_regs #(.IS_HIGH_SPEED(1'b0)) u_dut (.ref_clk_in(clk),
        .reset_n_in(rst_n), .amber_led_four_strap_in(strap),
        .cfg_req_in(req), .cfg_rsp_out(rsp_fs),
        .pm_capabilities_out(caps_fs), .strap_locked_out(lock_fs));
    ppm_cap_regs #(.IS_HIGH_SPEED(1'b1)) u_dut_hs (.ref_clk_in(clk),
        .reset_n_in(rst_n), .amber_led_four_strap_in(strap),
        .cfg_req_in(req), .cfg_rsp_out(rsp_hs),
        .pm_capabilities_out(caps_hs), .strap_locked_out(lock_hs));
    // Copy with a data register: standby current must read zero
    ppm_cap_regs #(.DATA_REG_PRESENT(1'b1)) u_dut_dr (.ref_clk_in(clk),
        .reset_n_in(rst_n), .amber_led_four_strap_in(strap),
        .cfg_req_in(req), .cfg_rsp_out(rsp_dr),
        .pm_capabilities_out(caps_dr), .strap_locked_out(lock_dr));

    // Expected word built field by field, bit 15 first
    function automatic logic [15:0] exp_caps(input logic hs, input logic s);
        exp_caps = {s, 1'b1, hs, 1'b1, hs, hs, 1'b1,
            (s ? PPM_AUX_100MA : 3'h0), 3'h0, 3'h2};
    endfunction : exp_caps

    // Read data by byte lane; link pointer and identifier lanes are zero
    function automatic logic [31:0] lanes(input logic rd,
        input logic [3:0] be, input logic here, input logic [15:0] c);
        lanes = 32'h0;
        if (rd && here)
            lanes = {be[3] ? c[15:8] : 8'h00, be[2] ? c[7:0] : 8'h00, 16'h0};
    endfunction : lanes

    task automatic chk(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic close_out();
        if (miscompares == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : close_out

    // Reset with a given strap, wait for lock, check the settled words
    task automatic do_reset(input logic s);
        int n;
        @(negedge clk);
        rst_n = 1'b0;
        strap = s;
        held = s;
        req = '0;
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        n = 0;
        while (!(lock_fs === 1'b1 && lock_hs === 1'b1 && lock_dr === 1'b1)
            && n < 20)
        begin
            @(negedge clk);
            n++;
        end
        if (n == 20)
        begin
            miscompares++;
            close_out();
        end
        repeat (2) @(negedge clk);
        chk("caps_fs", {16'h0, caps_fs}, {16'h0, exp_caps(1'b0, s)});
        chk("caps_hs", {16'h0, caps_hs}, {16'h0, exp_caps(1'b1, s)});
        chk("caps_dr", {16'h0, caps_dr},
            {16'h0, exp_caps(1'b0, s) & 16'hfe3f});
    endtask : do_reset

    // One access, called at a falling edge; consecutive calls go back to back
    task automatic acc(input logic rd, input logic wr, input logic [5:0] dw,
        input logic [3:0] be);
        logic here;
        here = (dw == BASE_DW);
        req = '{rd, wr, dw, be, 32'hffff_ffff};
        @(negedge clk);
        chk("ack_fs", {rsp_fs.ack, rsp_fs.hit}, {1'b1, here});
        chk("ack_hs", {rsp_hs.ack, rsp_hs.hit}, {1'b1, here});
        chk("rdata_fs", rsp_fs.rdata,
            lanes(rd, be, here, exp_caps(1'b0, held)));
        chk("rdata_hs", rsp_hs.rdata,
            lanes(rd, be, here, exp_caps(1'b1, held)));
    endtask : acc

    // Every byte-enable pattern on the capability dword
    task automatic sc_lanes();
        @(negedge clk);
        for (int b = 0; b < 16; b++)
            acc(1'b1, 1'b0, BASE_DW, b[3:0]);
        req = '0;
    endtask : sc_lanes

    // Writes complete but leave the word alone; read plus write reads
    task automatic sc_write();
        @(negedge clk);
        acc(1'b0, 1'b1, BASE_DW, 4'hf);
        acc(1'b1, 1'b1, BASE_DW, 4'hf);
        acc(1'b1, 1'b0, BASE_DW, 4'hf);
        req = '0;
    endtask : sc_write

    // Accesses beside the capability dword are not claimed
    task automatic sc_miss();
        @(negedge clk);
        acc(1'b1, 1'b0, PPM_CAP_PTR_LOC[7:2], 4'hf);
        acc(1'b1, 1'b0, BASE_DW + 6'h01, 4'hf);
        acc(1'b0, 1'b1, BASE_DW - 6'h01, 4'hf);
        req = '0;
    endtask : sc_miss

    // Strap moves after lock: word must not follow it
    task automatic sc_late_strap();
        @(negedge clk);
        strap = ~held;
        repeat (6) @(negedge clk);
        acc(1'b1, 1'b0, BASE_DW, 4'hc);
        req = '0;
    endtask : sc_late_strap

    initial
    begin
        do_reset(1'b0);
        sc_lanes();
        sc_write();
        sc_miss();
        sc_late_strap();
        do_reset(1'b1);
        sc_lanes();
        sc_write();
        sc_late_strap();
        close_out();
    end
endmodule : ppm_cap_regs_tb_top

bind ppm_cap_regs ppm_cap_regs_props #(.CAP_BASE(CAP_BASE),
    .IS_HIGH_SPEED(IS_HIGH_SPEED), .DATA_REG_PRESENT(DATA_REG_PRESENT),
    .AUX_CURRENT_CODE(AUX_CURRENT_CODE)) u_props (.ref_clk_in(ref_clk_in),
    .reset_n_in(reset_n_in),
    .amber_led_four_strap_in(amber_led_four_strap_in),
    .cfg_req_in(cfg_req_in), .cfg_rsp_out(cfg_rsp_out),
    .pm_capabilities_out(pm_capabilities_out),
    .strap_locked_out(strap_locked_out));

`default_nettype wire
